// File: pkg/adcomc_cfg.svh
// Function
// - Byte order select swaps parallel bus bytes.
// - Coding select low inverts MSB, two's complement.
// - Fast high, low-power low selects fastest mode.
// - Other modes keep accuracy at any rate.
// - Low-power mode powers analog core per conversion.
// - Serial/parallel select picks the data port.
// - Divider code sets internal serial clock period.
// - Busy width limit grows with code, mode.
// - Divider lines act only in master read-after-convert.
// - Read mode picks shift during or after conversion.
`ifndef ADCOMC_CFG_SVH
`define ADCOMC_CFG_SVH

`define ADCOMC_CLK_NS 8

`define ADCOMC_OFS_CTRL 12'h000
`define ADCOMC_OFS_STATUS 12'h004
`define ADCOMC_OFS_RESULT 12'h008
`define ADCOMC_OFS_BUSYMAX 12'h00C

`define ADCOMC_CTRL_RST 5'h02

`define ADCOMC_STAT_STALE 3
`define ADCOMC_STAT_REFUSED 4

`define ADCOMC_CONV_WARP_NS 750
`define ADCOMC_CONV_NORM_NS 1000
`define ADCOMC_CONV_IMP_NS 1250
`define ADCOMC_CONV_WARP_CYC (`ADCOMC_CONV_WARP_NS / `ADCOMC_CLK_NS)
`define ADCOMC_CONV_NORM_CYC (`ADCOMC_CONV_NORM_NS / `ADCOMC_CLK_NS)
`define ADCOMC_CONV_IMP_CYC (`ADCOMC_CONV_IMP_NS / `ADCOMC_CLK_NS)

`define ADCOMC_SCLK_P0_NS 25
`define ADCOMC_SCLK_P1_NS 50
`define ADCOMC_SCLK_P2_NS 100
`define ADCOMC_SCLK_P3_NS 200
`define ADCOMC_SCLK_P0_CYC ((`ADCOMC_SCLK_P0_NS + `ADCOMC_CLK_NS - 1) / `ADCOMC_CLK_NS)
`define ADCOMC_SCLK_P1_CYC ((`ADCOMC_SCLK_P1_NS + `ADCOMC_CLK_NS - 1) / `ADCOMC_CLK_NS)
`define ADCOMC_SCLK_P2_CYC ((`ADCOMC_SCLK_P2_NS + `ADCOMC_CLK_NS - 1) / `ADCOMC_CLK_NS)
`define ADCOMC_SCLK_P3_CYC ((`ADCOMC_SCLK_P3_NS + `ADCOMC_CLK_NS - 1) / `ADCOMC_CLK_NS)

`define ADCOMC_BUSY_W0_NS 1500
`define ADCOMC_BUSY_W1_NS 2000
`define ADCOMC_BUSY_W2_NS 3000
`define ADCOMC_BUSY_W3_NS 5250
`define ADCOMC_BUSY_ADD_N_NS 250
`define ADCOMC_BUSY_ADD_I_NS 500
`define ADCOMC_BUSY_W0_CYC (`ADCOMC_BUSY_W0_NS / `ADCOMC_CLK_NS)
`define ADCOMC_BUSY_W1_CYC (`ADCOMC_BUSY_W1_NS / `ADCOMC_CLK_NS)
`define ADCOMC_BUSY_W2_CYC (`ADCOMC_BUSY_W2_NS / `ADCOMC_CLK_NS)
`define ADCOMC_BUSY_W3_CYC (`ADCOMC_BUSY_W3_NS / `ADCOMC_CLK_NS)
`define ADCOMC_BUSY_ADD_N_CYC (`ADCOMC_BUSY_ADD_N_NS / `ADCOMC_CLK_NS)
`define ADCOMC_BUSY_ADD_I_CYC (`ADCOMC_BUSY_ADD_I_NS / `ADCOMC_CLK_NS)

`define ADCOMC_TAIL_NS 25
`define ADCOMC_TAIL_CYC ((`ADCOMC_TAIL_NS + `ADCOMC_CLK_NS - 1) / `ADCOMC_CLK_NS)

`define ADCOMC_WARP_GAP_NS 1000000

`endif

// File: pkg/adcomc_pkg.sv
`default_nettype none
package adcomc_pkg;

	typedef enum logic [1:0] {
		ADCOMC_WARP = 2'b00,
		ADCOMC_NORMAL = 2'b01,
		ADCOMC_IMPULSE = 2'b10
	} adcomc_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_SHIFT = 2'b11,
		ST_TAIL = 2'b10
	} adcomc_state_t;

	typedef struct packed {
		logic serial_parallel_select;
		logic low_power_mode_select;
		logic fast_mode_select;
		logic output_coding_select;
		logic byte_order_select;
	} adcomc_ctrl_t;

	typedef struct packed {
		logic serial_data_out;
		logic serial_data_out_oe_n;
		logic sclk_out;
		logic sclk_oe_n;
		logic sync_out;
		logic sync_oe_n;
	} adcomc_spin_t;

endpackage
`default_nettype wire

// File: logic/adcomc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcomc_cfg.svh"
module adcomc_top
	import adcomc_pkg::*;
#(
	parameter int WARP_GAP_CYCLES = `ADCOMC_WARP_GAP_NS / `ADCOMC_CLK_NS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic convert_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic sclk_in,
	input wire logic [15:0] d_in,
	output logic [15:0] d_out,
	output logic [15:0] d_oe_n,
	output adcomc_spin_t ser_pins,
	output logic busy,
	output logic analog_start,
	output adcomc_mode_t analog_mode,
	output logic analog_power_up,
	input wire logic [15:0] conv_raw
);

	adcomc_ctrl_t ctrl_q;
	adcomc_state_t state_q;
	adcomc_mode_t mode;
	adcomc_mode_t mode_q;
	logic [9:0] sync1_q;
	logic [9:0] sync2_q;
	logic [2:0] edge_q;
	logic cnv_n_s;
	logic cs_low;
	logic rd_n_s;
	logic sclk_s;
	logic ext_pin;
	logic rdc_pin;
	logic [1:0] div_pin;
	logic cnv_fall;
	logic rd_rise;
	logic sclk_rise;
	logic ser;
	logic master;
	logic slave;
	logic rac;
	logic rdc_mode;
	logic [1:0] div_eff;
	logic [4:0] per_len;
	logic [15:0] busy_base;
	logic [15:0] busy_add;
	logic [15:0] busy_max;
	logic [15:0] conv_len;
	logic [15:0] tmr_q;
	logic go;
	logic push;
	logic pop;
	logic [15:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	logic full;
	logic empty;
	logic [15:0] head;
	logic [15:0] fmt;
	logic [15:0] result_q;
	logic sh_act_q;
	logic [15:0] sh_q;
	logic [4:0] bit_q;
	logic [4:0] ph_q;
	logic sh_start;
	logic sh_pop_m;
	logic sh_pop_s;
	logic [15:0] pd_q;
	logic [15:0] poe_n_q;
	logic start_q;
	logic pwr_q;
	logic stale_q;
	logic refused_q;
	logic seen_q;
	logic [31:0] gap_q;
	logic apb_setup;
	logic apb_wr;
	logic hit;
	logic [31:0] rd_mux;
	logic [31:0] status_v;

	// The control pins and d_in[7:2] pass two flops; a third stage serves edge detection.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 10'h380;
			sync2_q <= 10'h380;
			edge_q <= 3'b110;
		end else begin
			sync1_q <= {convert_start_n, cs_n, rd_n, sclk_in, d_in[7:2]};
			sync2_q <= sync1_q;
			edge_q <= {cnv_n_s, rd_n_s, sclk_s};
		end
	end

	assign cnv_n_s = sync2_q[9];
	assign cs_low = !sync2_q[8];
	assign rd_n_s = sync2_q[7];
	assign sclk_s = sync2_q[6];
	assign rdc_pin = sync2_q[5];
	assign ext_pin = sync2_q[2];
	assign div_pin = sync2_q[1:0];
	assign cnv_fall = edge_q[2] && !cnv_n_s;
	assign rd_rise = !edge_q[1] && rd_n_s;
	assign sclk_rise = !edge_q[0] && sclk_s;

	always_comb begin
		if (ctrl_q.fast_mode_select && !ctrl_q.low_power_mode_select) begin
			mode = ADCOMC_WARP;
		end else if (ctrl_q.low_power_mode_select && !ctrl_q.fast_mode_select) begin
			mode = ADCOMC_IMPULSE;
		end else begin
			mode = ADCOMC_NORMAL;
		end
	end

	assign ser = ctrl_q.serial_parallel_select;
	assign master = ser && !ext_pin;
	assign slave = ser && ext_pin;
	assign rac = master && !rdc_pin;
	assign rdc_mode = master && rdc_pin;
	assign div_eff = rac ? div_pin : 2'b00;

	always_comb begin
		case (div_eff)
			2'b00: begin
				per_len = 5'(`ADCOMC_SCLK_P0_CYC);
				busy_base = 16'(`ADCOMC_BUSY_W0_CYC);
			end
			2'b01: begin
				per_len = 5'(`ADCOMC_SCLK_P1_CYC);
				busy_base = 16'(`ADCOMC_BUSY_W1_CYC);
			end
			2'b10: begin
				per_len = 5'(`ADCOMC_SCLK_P2_CYC);
				busy_base = 16'(`ADCOMC_BUSY_W2_CYC);
			end
			default: begin
				per_len = 5'(`ADCOMC_SCLK_P3_CYC);
				busy_base = 16'(`ADCOMC_BUSY_W3_CYC);
			end
		endcase
	end

	always_comb begin
		case (mode)
			ADCOMC_WARP: begin
				conv_len = 16'(`ADCOMC_CONV_WARP_CYC);
				busy_add = 16'h0000;
			end
			ADCOMC_IMPULSE: begin
				conv_len = 16'(`ADCOMC_CONV_IMP_CYC);
				busy_add = 16'(`ADCOMC_BUSY_ADD_I_CYC);
			end
			default: begin
				conv_len = 16'(`ADCOMC_CONV_NORM_CYC);
				busy_add = 16'(`ADCOMC_BUSY_ADD_N_CYC);
			end
		endcase
	end

	assign busy_max = busy_base + busy_add;

	// A start while the buffer is full is refused so no result is lost.
	assign full = cnt_q == 2'd2;
	assign empty = cnt_q == 2'd0;
	assign go = (state_q == ST_IDLE) && cnv_fall && !full;
	assign push = (state_q == ST_CONV) && (tmr_q == 16'h0000);
	assign head = mem_q[rp_q];
	assign fmt = {conv_raw[15] ^ !ctrl_q.output_coding_select, conv_raw[14:0]};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			tmr_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (go) begin
						state_q <= ST_CONV;
						tmr_q <= conv_len - 16'h0001;
					end
				end
				ST_CONV: begin
					if (tmr_q == 16'h0000) begin
						state_q <= rac ? ST_SHIFT : ST_IDLE;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				ST_SHIFT: begin
					if (sh_pop_m || !rac) begin
						state_q <= ST_TAIL;
						tmr_q <= 16'(`ADCOMC_TAIL_CYC - 1);
					end
				end
				ST_TAIL: begin
					if (tmr_q == 16'h0000) begin
						state_q <= ST_IDLE;
					end else begin
						tmr_q <= tmr_q - 16'h0001;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign busy = state_q != ST_IDLE;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_q <= 1'b0;
			mode_q <= ADCOMC_NORMAL;
			pwr_q <= 1'b1;
		end else begin
			start_q <= go;
			mode_q <= mode;
			pwr_q <= (mode != ADCOMC_IMPULSE) || go || (state_q != ST_IDLE);
		end
	end

	assign analog_start = start_q;
	assign analog_mode = mode_q;
	assign analog_power_up = pwr_q;

	// Two-entry result buffer.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'd0;
			result_q <= 16'h0000;
		end else begin
			if (push && !full) begin
				wp_q <= !wp_q;
				result_q <= fmt;
			end
			if (pop) begin
				rp_q <= !rp_q;
			end
			cnt_q <= cnt_q + 2'((push && !full) ? 1 : 0) - 2'(pop ? 1 : 0);
		end
	end

	always_ff @(posedge clk) begin
		if (push && !full) begin
			mem_q[wp_q] <= fmt;
		end
	end

	assign sh_start = !sh_act_q && !empty && ser
		&& ((state_q == ST_SHIFT) || (rdc_mode && go) || (slave && cs_low));
	assign sh_pop_m = sh_act_q && master && (ph_q == per_len - 5'd1) && (bit_q == 5'd15);
	assign sh_pop_s = sh_act_q && slave && cs_low && sclk_rise && (bit_q == 5'd15);
	assign pop = (!ser && cs_low && rd_rise && !empty) || sh_pop_m || sh_pop_s;

	// Serial shifter, MSB first; in slave mode the chain input follows the word.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_act_q <= 1'b0;
			sh_q <= 16'h0000;
			bit_q <= 5'd0;
			ph_q <= 5'd0;
		end else if (!ser) begin
			sh_act_q <= 1'b0;
		end else if (!sh_act_q) begin
			if (sh_start) begin
				sh_act_q <= 1'b1;
				sh_q <= head;
				bit_q <= 5'd0;
				ph_q <= 5'd0;
			end
		end else if (slave) begin
			if (!cs_low) begin
				sh_act_q <= 1'b0;
			end else if (sclk_rise) begin
				sh_q <= {sh_q[14:0], rdc_pin};
				if (bit_q != 5'd16) begin
					bit_q <= bit_q + 5'd1;
				end
			end
		end else if (ph_q == per_len - 5'd1) begin
			ph_q <= 5'd0;
			if (bit_q == 5'd15) begin
				sh_act_q <= 1'b0;
			end else begin
				sh_q <= {sh_q[14:0], 1'b0};
				bit_q <= bit_q + 5'd1;
			end
		end else begin
			ph_q <= ph_q + 5'd1;
		end
	end

	assign ser_pins.serial_data_out = sh_q[15];
	assign ser_pins.serial_data_out_oe_n = !(ser && cs_low);
	assign ser_pins.sclk_out = sh_act_q && master && (ph_q >= (per_len >> 1));
	assign ser_pins.sclk_oe_n = !(master && cs_low);
	assign ser_pins.sync_out = sh_act_q && master;
	assign ser_pins.sync_oe_n = !(master && cs_low);

	// Parallel port; all lines float in serial mode, divider lines included.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pd_q <= 16'h0000;
			poe_n_q <= 16'hFFFF;
		end else begin
			pd_q <= ctrl_q.byte_order_select ? {head[7:0], head[15:8]} : head;
			poe_n_q <= {16{!(!ser && cs_low && !rd_n_s)}};
		end
	end

	assign d_out = pd_q;
	assign d_oe_n = poe_n_q;

	// Gap watchdog: flags a fastest-mode result that may have lost accuracy.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_q <= 32'h0000_0000;
			seen_q <= 1'b0;
		end else if (go) begin
			gap_q <= 32'h0000_0000;
			seen_q <= 1'b1;
		end else if (seen_q && (mode == ADCOMC_WARP) && (gap_q != 32'(WARP_GAP_CYCLES))) begin
			gap_q <= gap_q + 32'h0000_0001;
		end else if (mode != ADCOMC_WARP) begin
			gap_q <= 32'h0000_0000;
		end
	end

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign hit = (paddr == `ADCOMC_OFS_CTRL) || (paddr == `ADCOMC_OFS_STATUS)
		|| (paddr == `ADCOMC_OFS_RESULT) || (paddr == `ADCOMC_OFS_BUSYMAX);
	assign status_v = {22'h00_0000, sh_act_q, div_eff, mode, refused_q, stale_q, cnt_q, busy};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stale_q <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			if (seen_q && (mode == ADCOMC_WARP) && (gap_q == 32'(WARP_GAP_CYCLES) - 32'h0000_0001)) begin
				stale_q <= 1'b1;
			end else if (apb_wr && (paddr == `ADCOMC_OFS_STATUS) && pwdata[`ADCOMC_STAT_STALE]) begin
				stale_q <= 1'b0;
			end
			if ((state_q == ST_IDLE) && cnv_fall && full) begin
				refused_q <= 1'b1;
			end else if (apb_wr && (paddr == `ADCOMC_OFS_STATUS) && pwdata[`ADCOMC_STAT_REFUSED]) begin
				refused_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `ADCOMC_CTRL_RST;
		end else if (apb_wr && (paddr == `ADCOMC_OFS_CTRL)) begin
			ctrl_q <= pwdata[4:0];
		end
	end

	always_comb begin
		case (paddr)
			`ADCOMC_OFS_CTRL: rd_mux = {27'h000_0000, ctrl_q};
			`ADCOMC_OFS_STATUS: rd_mux = status_v;
			`ADCOMC_OFS_RESULT: rd_mux = {16'h0000, result_q};
			`ADCOMC_OFS_BUSYMAX: rd_mux = {16'h0000, busy_max};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata <= rd_mux;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

endmodule
`default_nettype wire

// File: bench/adcomc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adcomc_monitor
	import adcomc_pkg::*;
#(
	parameter int WARP_GAP_CYCLES = 200
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy,
	input wire logic analog_start,
	input wire adcomc_mode_t analog_mode,
	input wire logic analog_power_up
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_begin;
		analog_start && busy;
	endsequence
	sequence s_running;
		busy && $past(busy);
	endsequence
	chk_start_with_busy: assert property (analog_start |-> s_begin ##1 (busy && !analog_start))
		else $error("conversion start without busy");
	chk_busy_min_hold: assert property (s_begin |-> busy [*8])
		else $error("busy dropped early");
	chk_busy_max_width: assert property ($rose(busy) |-> ##[1:720] !busy)
		else $error("busy too long");
	chk_no_restart: assert property (s_running |-> !analog_start)
		else $error("start accepted while busy");
	chk_power_mode: assert property (!analog_power_up |-> analog_mode == ADCOMC_IMPULSE)
		else $error("power down outside reduced power mode");
	chk_power_in_conv: assert property (s_running |-> analog_power_up)
		else $error("power down during conversion");
	chk_mode_steady: assert property (s_running |-> $stable(analog_mode))
		else $error("mode changed during conversion");
	chk_slverr_map: assert property (s_access |-> pready && (pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})))
		else $error("slave error does not match address map");
endmodule
bind adcomc_top adcomc_monitor #(.WARP_GAP_CYCLES(WARP_GAP_CYCLES)) u_mon (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .busy(busy), .analog_start(analog_start),
	.analog_mode(analog_mode), .analog_power_up(analog_power_up));
`default_nettype wire

// File: bench/adcomc_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcomc_host
	import adcomc_pkg::*;
(
	input wire logic clk,
	output logic convert_start_n,
	output logic cs_n,
	output logic rd_n,
	output logic sclk_in,
	output logic [15:0] d_in,
	input wire logic [15:0] d_out,
	input wire logic [15:0] d_oe_n,
	input wire adcomc_spin_t ser_pins
);
	logic [15:0] pin_cfg = 16'h0000;
	logic [15:0] sh;
	logic sclk_prev = 1'b0;
	int cyc = 0;
	int last = 0;
	int per = 0;
	initial begin
		{convert_start_n, cs_n, rd_n, sclk_in, d_in} = {4'b1110, 16'h0000};
	end
	// Unused bus lines take random values every cycle; divider bits are only strapped in read-after-convert.
	always @(posedge clk) d_in <= 16'($urandom) & ~16'h009C | pin_cfg;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		sclk_prev <= ser_pins.sclk_out;
		if (ser_pins.sclk_out && !sclk_prev && ser_pins.sync_out) begin
			sh <= {sh[14:0], ser_pins.serial_data_out};
			per <= cyc - last;
			last <= cyc;
		end
	end
	task automatic convert();
		@(posedge clk);
		convert_start_n <= 1'b0;
		repeat (4) @(posedge clk);
		convert_start_n <= 1'b1;
	endtask
	task automatic read_par(output logic [15:0] w);
		int n;
		n = 0;
		@(posedge clk);
		{cs_n, rd_n} <= 2'b00;
		while (d_oe_n !== 16'h0000 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			tb.err_total++;
		end
		repeat (2) @(posedge clk);
		w = d_out;
		rd_n <= 1'b1;
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// The external clock runs at ten system cycles per period and idles low between frames.
	task automatic read_slave(output logic [15:0] w);
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			w = {w[14:0], ser_pins.serial_data_out};
			sclk_in <= 1'b1;
			repeat (5) @(posedge clk);
			sclk_in <= 1'b0;
			repeat (5) @(posedge clk);
		end
		cs_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adcomc_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, busy, analog_start, analog_power_up, slv;
	logic convert_start_n, cs_n, rd_n, sclk_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] conv_raw, d_out, d_oe_n, d_in, w, r, e;
	logic [4:0] c;
	adcomc_spin_t ser_pins;
	adcomc_mode_t analog_mode, seen_mode;
	int err_total = 0;
	int check_count = 0;
	// Longest busy time per divider code in normal mode, in ns.
	int bw[4] = '{1750, 2250, 3250, 5500};
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	adcomc_top #(.WARP_GAP_CYCLES(200)) uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in), .d_in(d_in), .d_out(d_out),
		.d_oe_n(d_oe_n), .ser_pins(ser_pins), .busy(busy), .analog_start(analog_start), .analog_mode(analog_mode),
		.analog_power_up(analog_power_up), .conv_raw(conv_raw));
	adcomc_host host (.clk(clk), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in),
		.d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n), .ser_pins(ser_pins));
	always @(posedge clk) if (analog_start === 1'b1) seen_mode <= analog_mode;
	function automatic logic [15:0] fmt(input logic [15:0] v, input logic [4:0] k);
		return k[1] ? v : v ^ 16'h8000;
	endfunction
	function automatic logic [1:0] mode_of(input logic [4:0] k);
		return (k[2] && !k[3]) ? 2'b00 : (k[3] && !k[2]) ? 2'b10 : 2'b01;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic conv(input logic [15:0] v);
		int n;
		n = 0;
		@(posedge clk);
		conv_raw <= v;
		host.convert();
		while ((busy !== 1'b0 || n < 2) && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 1000) begin
			err_total++;
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		stop_test();
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, conv_raw} = '0;
		void'($urandom(80166));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		apb(0, 12'h000, 32'h0000_0000);
		check(rd, 32'h0000_0002);
		check(slv, 1'b0);
		apb(0, 12'h010, 32'h0000_0000);
		check(slv, 1'b1);
		for (int i = 0; i < 12; i++) begin
			c = (i < 4) ? 5'(i * 5) : 5'($urandom) & 5'h0F;
			r = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : (i == 2) ? 16'h8000 : 16'($urandom);
			e = fmt(r, c);
			apb(1, 12'h000, {27'h0, c});
			conv(r);
			check(seen_mode, mode_of(c));
			apb(0, 12'h008, 32'h0000_0000);
			check(rd, {16'h0000, e});
			host.read_par(w);
			check(w, c[0] ? {e[7:0], e[15:8]} : e);
		end
		apb(1, 12'h000, 32'h0000_0002);
		apb(1, 12'h004, 32'h0000_0018);
		conv(16'h1234);
		conv(16'h5678);
		conv(16'h9ABC);
		apb(0, 12'h004, 32'h0000_0000);
		check(rd[4:1], 4'b1010);
		apb(1, 12'h004, 32'h0000_0018);
		host.read_par(w);
		check(w, 16'h1234);
		host.read_par(w);
		check(w, 16'h5678);
		apb(0, 12'h004, 32'h0000_0000);
		check(rd[4:1], 4'b0000);
		host.cs_n <= 1'b0;
		for (int dv = 0; dv < 4; dv++) begin
			host.pin_cfg <= 16'(dv << 2);
			apb(1, 12'h000, 32'h0000_0012);
			r = 16'($urandom);
			conv(r);
			check(host.sh, r);
			check(host.per, ((25 << dv) + 7) / 8);
			apb(0, 12'h00C, 32'h0000_0000);
			check(rd, 32'(bw[dv] / 8));
		end
		host.cs_n <= 1'b1;
		host.pin_cfg <= 16'h0010;
		r = 16'($urandom);
		conv(r);
		host.read_slave(w);
		check(w, r);
		host.pin_cfg <= 16'h0080;
		apb(1, 12'h000, 32'h0000_0012);
		conv(16'hA55A);
		conv(16'h0F0F);
		check(host.sh, 16'hA55A);
		apb(1, 12'h000, 32'h0000_0006);
		conv(16'($urandom));
		repeat (210) @(posedge clk);
		apb(0, 12'h004, 32'h0000_0000);
		check(rd[3], 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
